// ---- rtl/bank_consts.svh ----
/*
 * Constants of the second special register bank: register indices, the
 * extra bank-side registers, field positions, reset values and write masks.
 * Assumes the including file uses the indices with an 8-bit index bus.
 */
// Overview of operation
// R1: serial mode 1001 steers offset 93h to the address mask register.
// R2: port pins set analog by the analog selects read as zero.
// R3: port output latches survive external pin and watchdog resets.
// R4: reset clears the port B change flag; a lasting mismatch sets it again (here only after software rewrites the change enables, which reset clears).
// R5: unimplemented bits and locations read zero and ignore writes.
// R6: power-on/brown-out loads one value set, other resets the second set.
`ifndef BANK_CONSTS_SVH
`define BANK_CONSTS_SVH

// ============================================================
// register indices (byte address = 4 * index)
`define IDX_INDIRECT_DATA     8'h80
`define IDX_PRESCALER_OPTION  8'h81
`define IDX_PC_LOW            8'h82
`define IDX_CPU_STATUS        8'h83
`define IDX_INDIRECT_POINTER  8'h84
`define IDX_PORT_A_DIR        8'h85
`define IDX_PORT_B_DIR        8'h86
`define IDX_PORT_C_DIR        8'h87
`define IDX_PORT_D_DIR        8'h88
`define IDX_PORT_E_DIR        8'h89
`define IDX_PC_HIGH_LATCH     8'h8A
`define IDX_CORE_IRQ_CTRL     8'h8B
`define IDX_PERIPH_IE_ONE     8'h8C
`define IDX_PERIPH_IE_TWO     8'h8D
`define IDX_POWER_FLAGS       8'h8E
`define IDX_OSC_CONTROL       8'h8F
`define IDX_OSC_TUNING        8'h90
`define IDX_SERIAL_CTRL_TWO   8'h91
`define IDX_TIMER2_PERIOD     8'h92
`define IDX_SERIAL_ADDRESS    8'h93
`define IDX_SERIAL_STATE      8'h94
`define IDX_PORT_B_PULLUP     8'h95
`define IDX_PORT_B_CHANGE_IE  8'h96
`define IDX_VREF_CONTROL      8'h97
`define IDX_TX_CONTROL        8'h98
`define IDX_BAUD_LOW          8'h99
`define IDX_BAUD_HIGH         8'h9A
`define IDX_PWM_RESTART       8'h9B
`define IDX_PWM_SHUTDOWN      8'h9C
`define IDX_PWM_STEERING      8'h9D
`define IDX_RESULT_LOW        8'h9E
`define IDX_CONVERTER_CFG     8'h9F
// bank-side registers outside the printed range
`define IDX_PORT_A_LATCH      8'hA0
`define IDX_PORT_B_LATCH      8'hA1
`define IDX_ANALOG_SEL_LOW    8'hA2
`define IDX_ANALOG_SEL_HIGH   8'hA3
`define IDX_EVENT_STATUS      8'hA4
`define IDX_EVENT_MASK        8'hA5
`define IDX_PORT_A_READ       8'hA6
`define IDX_PORT_B_READ       8'hA7

// ============================================================
// fields
`define ALIAS_MODE            4'h9
`define STATUS_TO_BIT         4
`define STATUS_PD_BIT         3
`define CHANGE_FLAG_BIT       0
`define POWER_ULPWU_BIT       5
`define EV_PORT_B_CHANGE      0
`define EV_EXTERNAL_RESET     1
`define EV_WATCHDOG_RESET     2
`define EV_BROWNOUT_RESET     3

// ============================================================
// power-on / brown-out values (others are zero)
`define POR_ALL_ONES          8'hFF
`define POR_ZERO              8'h00
`define POR_CPU_STATUS        8'h18
`define POR_PORT_E_DIR        8'h0F
`define POR_POWER_FLAGS       8'h10
`define POR_OSC_CONTROL       8'h60
`define POR_TX_CONTROL        8'h02
`define POR_PWM_STEERING      8'h01
`define POR_EVENT_ZERO        4'h0

// ============================================================
// writable bits per register
`define WM_NONE               8'h00
`define WM_CPU_STATUS         8'hE7
`define WM_PORT_E_DIR         8'h0F
`define WM_PC_HIGH_LATCH      8'h1F
`define WM_CORE_IRQ_CTRL      8'hFE
`define WM_PERIPH_IE_ONE      8'h7F
`define WM_PERIPH_IE_TWO      8'hFD
`define WM_POWER_FLAGS        8'h33
`define WM_OSC_CONTROL        8'h71
`define WM_OSC_TUNING         8'h1F
`define WM_SERIAL_STATE       8'hC0
`define WM_TX_CONTROL         8'hFD
`define WM_PWM_STEERING       8'h1F
`define WM_CONVERTER_CFG      8'hB0

`endif

// ---- rtl/bank_types_pkg.sv ----
/*
 * Types shared by the special register bank and its helper modules.
 * Assumes bank_consts.svh for the reset values it refers to.
 */
package bank_types_pkg;

    typedef logic [31:0][7:0] reg_array_t;

    typedef struct packed {
        reg_array_t  regs;
        logic [7:0]  addr_mask;
        logic [7:0]  port_a_latch;
        logic [7:0]  port_b_latch;
        logic [7:0]  analog_low;
        logic [7:0]  analog_high;
        logic [3:0]  ev_status;
        logic [3:0]  ev_mask;
        logic [7:0]  rdata;
        logic        ready;
        logic        slverr;
        logic        irq;
    } bank_state_t;

    typedef struct packed {
        logic [7:0]  last_seen;
    } change_state_t;

    typedef enum logic [1:0] {
        reset_kind_none,
        reset_kind_power,
        reset_kind_other
    } reset_kind_t;

endpackage

// ---- rtl/pin_sync.sv ----
/*
 * Two-flop synchroniser for pin levels.
 * Assumes inputs are asynchronous levels, not pulses.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t st_ff;
    sync_state_t nxt_st;

    always_comb begin
        nxt_st        = st_ff;
        nxt_st.meta   = async_in;
        nxt_st.stable = st_ff.meta;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sync_out = st_ff.stable;
endmodule
`default_nettype wire

// ---- rtl/port_change_detect.sv ----
/*
 * Port B change detector: holds the value latched at the last port read and
 * reports a mismatch on enabled pins.
 * Assumes pins are already synchronised to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module port_change_detect import bank_types_pkg::*; (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] pins,
    input  wire logic [7:0] enable,
    input  wire logic       snap,
    output var  logic       mismatch
);
    change_state_t st_ff;
    change_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (snap) begin
            nxt_st.last_seen = pins;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign mismatch = |((pins ^ st_ff.last_seen) & enable); // see R4
endmodule
`default_nettype wire

// ---- rtl/special_register_bank_one.sv ----
/*
 * Second special register bank behind an APB slave, with port latches,
 * analog read masking, the port B change flag and a reset-event interrupt.
 * Assumes the serial mode field, oscillator status, watchdog and brown-out
 * strobes come from logic on clk; port pins and the reset pin are async.
 */
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "bank_consts.svh"
module special_register_bank_one import bank_types_pkg::*; (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [3:0]  sync_serial_mode_select,
    input  wire logic [2:0]  osc_status,
    input  wire logic [7:0]  port_a_pins,
    input  wire logic [7:0]  port_b_pins,
    input  wire logic        external_reset_pin_n,
    input  wire logic        watchdog_reset_source,
    input  wire logic        brownout_reset,
    output logic             irq,
    output logic      [7:0]  port_a_latch,
    output logic      [7:0]  port_b_latch,
    output logic      [7:0]  port_a_dir,
    output logic      [7:0]  port_b_dir,
    output logic      [7:0]  port_b_pullup,
    output logic      [7:0]  prescaler_edge_option
);

    // ============================================================
    // reset and write tables
    function automatic logic [7:0] por_value(input logic [7:0] idx);
        logic [7:0] v;
        v = `POR_ZERO;
        unique case (idx)
            `IDX_PRESCALER_OPTION,
            `IDX_PORT_A_DIR,
            `IDX_PORT_B_DIR,
            `IDX_PORT_C_DIR,
            `IDX_PORT_D_DIR,
            `IDX_TIMER2_PERIOD,
            `IDX_PORT_B_PULLUP:   v = `POR_ALL_ONES;
            `IDX_CPU_STATUS:      v = `POR_CPU_STATUS;
            `IDX_PORT_E_DIR:      v = `POR_PORT_E_DIR;
            `IDX_POWER_FLAGS:     v = `POR_POWER_FLAGS;
            `IDX_OSC_CONTROL:     v = `POR_OSC_CONTROL;
            `IDX_TX_CONTROL:      v = `POR_TX_CONTROL;
            `IDX_PWM_STEERING:    v = `POR_PWM_STEERING;
            default:              v = `POR_ZERO;
        endcase
        return v;
    endfunction

    // values on external pin and watchdog resets
    function automatic logic [7:0] other_value(input logic [7:0] idx,
                                               input logic [7:0] cur,
                                               input logic       by_watchdog);
        logic [7:0] v;
        v = por_value(idx);
        unique case (idx)
            `IDX_INDIRECT_POINTER,
            `IDX_OSC_TUNING,
            `IDX_RESULT_LOW:      v = cur;
            `IDX_CPU_STATUS: begin
                v = {3'b000, ~by_watchdog, 1'b1, cur[2:0]};
            end
            `IDX_POWER_FLAGS: begin
                v = cur;
                v[`POWER_ULPWU_BIT] = 1'b0;
            end
            default:              v = por_value(idx);
        endcase
        return v;
    endfunction

    // writable bits; unlisted bits keep their value, except a zero written to the change flag (see R5)
    function automatic logic [7:0] write_mask(input logic [7:0] idx);
        logic [7:0] m;
        m = `POR_ALL_ONES;
        unique case (idx)
            `IDX_INDIRECT_DATA:   m = `WM_NONE;
            `IDX_CPU_STATUS:      m = `WM_CPU_STATUS;
            `IDX_PORT_E_DIR:      m = `WM_PORT_E_DIR;
            `IDX_PC_HIGH_LATCH:   m = `WM_PC_HIGH_LATCH;
            `IDX_CORE_IRQ_CTRL:   m = `WM_CORE_IRQ_CTRL;
            `IDX_PERIPH_IE_ONE:   m = `WM_PERIPH_IE_ONE;
            `IDX_PERIPH_IE_TWO:   m = `WM_PERIPH_IE_TWO;
            `IDX_POWER_FLAGS:     m = `WM_POWER_FLAGS;
            `IDX_OSC_CONTROL:     m = `WM_OSC_CONTROL;
            `IDX_OSC_TUNING:      m = `WM_OSC_TUNING;
            `IDX_SERIAL_STATE:    m = `WM_SERIAL_STATE;
            `IDX_TX_CONTROL:      m = `WM_TX_CONTROL;
            `IDX_PWM_STEERING:    m = `WM_PWM_STEERING;
            `IDX_CONVERTER_CFG:   m = `WM_CONVERTER_CFG;
            default:              m = `POR_ALL_ONES;
        endcase
        return m;
    endfunction

    function automatic logic [7:0] slot_index(input int i);
        return 8'(`IDX_INDIRECT_DATA + i);
    endfunction

    function automatic bank_state_t power_state();
        bank_state_t s;
        s = '0;
        for (int i = 0; i < 32; i++) begin
            s.regs[i] = por_value(slot_index(i)); // see R6
        end
        s.addr_mask   = `POR_ALL_ONES;
        s.analog_low  = `POR_ALL_ONES;
        s.analog_high = `POR_ALL_ONES;
        s.ev_status   = `POR_EVENT_ZERO;
        s.ev_mask     = `POR_EVENT_ZERO;
        return s;
    endfunction

    localparam bank_state_t ST_POWER = power_state();

    // ============================================================
    // pin synchronisers and change detection
    logic [16:0] pins_sync;
    logic        change_mismatch;
    logic        port_b_snap;

    pin_sync #(
        .WIDTH    (17)
    ) u_pin_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in ({external_reset_pin_n, port_b_pins, port_a_pins}),
        .sync_out (pins_sync)
    );

    bank_state_t st_ff;
    bank_state_t nxt_st;

    port_change_detect u_change (
        .clk      (clk),
        .reset_n  (reset_n),
        .pins     (pins_sync[15:8]),
        .enable   (st_ff.regs[5'(`IDX_PORT_B_CHANGE_IE - `IDX_INDIRECT_DATA)]),
        .snap     (port_b_snap),
        .mismatch (change_mismatch)
    );

    // ============================================================
    // register next state
    logic [7:0]  idx;
    logic [4:0]  slot;
    logic        in_bank;
    logic        in_extra;
    logic        hit;
    logic        alias_mask;
    logic        setup;
    logic        access;
    logic [7:0]  wdata;
    logic [7:0]  rd;
    logic [7:0]  cur_flags;
    logic        flag_set;
    reset_kind_t rkind;

    always_comb begin
        nxt_st     = st_ff;
        idx        = paddr[9:2];
        slot       = idx[4:0];
        in_bank    = (idx[7:5] == 3'b100);
        in_extra   = (idx[7:3] == 5'b10100);
        hit        = (in_bank | in_extra) & (paddr[1:0] == 2'b00);
        alias_mask = (idx == `IDX_SERIAL_ADDRESS) &&
                     (sync_serial_mode_select == `ALIAS_MODE); // see R1
        setup      = psel & ~penable;
        access     = psel & penable & st_ff.ready;
        wdata      = pwdata[7:0];
        rd         = 8'h00;
        cur_flags  = 8'h00;
        flag_set   = 1'b0;
        port_b_snap = access & ~pwrite & hit & (idx == `IDX_PORT_B_READ);

        // read data is fixed at the setup edge; zero-wait access phase
        if (in_bank) begin
            rd = st_ff.regs[slot];
        end
        unique case (idx)
            `IDX_INDIRECT_DATA:   rd = 8'h00;
            `IDX_SERIAL_ADDRESS:  rd = alias_mask ? st_ff.addr_mask : st_ff.regs[slot];
            `IDX_OSC_CONTROL:     rd = {st_ff.regs[slot][7:4], osc_status, st_ff.regs[slot][0]};
            `IDX_PORT_A_LATCH:    rd = st_ff.port_a_latch;
            `IDX_PORT_B_LATCH:    rd = st_ff.port_b_latch;
            `IDX_ANALOG_SEL_LOW:  rd = st_ff.analog_low;
            `IDX_ANALOG_SEL_HIGH: rd = st_ff.analog_high;
            `IDX_EVENT_STATUS:    rd = {4'h0, st_ff.ev_status};
            `IDX_EVENT_MASK:      rd = {4'h0, st_ff.ev_mask};
            // analog pins never show digital levels, latch regardless
            `IDX_PORT_A_READ:     rd = pins_sync[7:0] & ~st_ff.analog_low; // see R2
            `IDX_PORT_B_READ:     rd = pins_sync[15:8] & ~st_ff.analog_high; // see R2
            default:              rd = rd;
        endcase

        nxt_st.ready = setup;
        if (setup) begin
            nxt_st.rdata  = hit ? rd : 8'h00; // see R5
            nxt_st.slverr = ~hit;
        end

        // software writes
        if (access && pwrite && hit) begin
            if (alias_mask) begin
                nxt_st.addr_mask = wdata; // see R1
            end else if (in_bank) begin
                nxt_st.regs[slot] = (st_ff.regs[slot] & ~write_mask(idx)) |
                                    (wdata & write_mask(idx)); // see R5
                if (idx == `IDX_CORE_IRQ_CTRL && !wdata[`CHANGE_FLAG_BIT]) begin
                    nxt_st.regs[slot][`CHANGE_FLAG_BIT] = 1'b0;
                end
            end
            unique case (idx)
                `IDX_PORT_A_LATCH:    nxt_st.port_a_latch = wdata;
                `IDX_PORT_B_LATCH:    nxt_st.port_b_latch = wdata;
                `IDX_ANALOG_SEL_LOW:  nxt_st.analog_low   = wdata;
                `IDX_ANALOG_SEL_HIGH: nxt_st.analog_high  = wdata;
                `IDX_EVENT_STATUS:    nxt_st.ev_status    = st_ff.ev_status & ~wdata[3:0];
                `IDX_EVENT_MASK:      nxt_st.ev_mask      = wdata[3:0];
                default:              nxt_st.ev_mask      = nxt_st.ev_mask;
            endcase
        end

        // device resets other than reset_n
        rkind = reset_kind_none;
        if (brownout_reset) begin
            rkind = reset_kind_power;
        end else if (!pins_sync[16] || watchdog_reset_source) begin
            rkind = reset_kind_other;
        end

        unique case (rkind)
            reset_kind_power: begin
                // latches are undefined after power loss, so left as they are
                nxt_st.regs        = ST_POWER.regs; // see R6
                nxt_st.addr_mask   = ST_POWER.addr_mask;
                nxt_st.analog_low  = ST_POWER.analog_low;
                nxt_st.analog_high = ST_POWER.analog_high;
            end
            reset_kind_other: begin
                for (int i = 0; i < 32; i++) begin
                    nxt_st.regs[i] = other_value(slot_index(i), st_ff.regs[i],
                                                 watchdog_reset_source); // see R6
                end
                nxt_st.addr_mask   = ST_POWER.addr_mask;
                nxt_st.analog_low  = ST_POWER.analog_low;
                nxt_st.analog_high = ST_POWER.analog_high;
                // port output latches deliberately untouched (see R3)
            end
            reset_kind_none: begin
                // hardware set beats a software clear in the same cycle
                cur_flags = st_ff.regs[5'(`IDX_CORE_IRQ_CTRL - `IDX_INDIRECT_DATA)];
                if (change_mismatch) begin
                    nxt_st.regs[5'(`IDX_CORE_IRQ_CTRL - `IDX_INDIRECT_DATA)]
                        [`CHANGE_FLAG_BIT] = 1'b1; // see R4
                    flag_set = ~cur_flags[`CHANGE_FLAG_BIT];
                end
            end
        endcase
        // reset cycle clears the change flag and the port B change enables; it sets again once they are rewritten (see R4)

        // sticky events, set wins over write-one-to-clear
        if (flag_set) begin
            nxt_st.ev_status[`EV_PORT_B_CHANGE] = 1'b1;
        end
        if (!pins_sync[16]) begin
            nxt_st.ev_status[`EV_EXTERNAL_RESET] = 1'b1;
        end
        if (watchdog_reset_source) begin
            nxt_st.ev_status[`EV_WATCHDOG_RESET] = 1'b1;
        end
        if (brownout_reset) begin
            nxt_st.ev_status[`EV_BROWNOUT_RESET] = 1'b1;
        end
        nxt_st.irq = |(nxt_st.ev_status & nxt_st.ev_mask);
    end

    // ============================================================
    // state register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= ST_POWER;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ============================================================
    // outputs
    assign prdata                = {24'h000000, st_ff.rdata};
    assign pready                = st_ff.ready;
    assign pslverr               = st_ff.slverr;
    assign irq                   = st_ff.irq;
    assign port_a_latch          = st_ff.port_a_latch;
    assign port_b_latch          = st_ff.port_b_latch;
    assign port_a_dir            = st_ff.regs[5'(`IDX_PORT_A_DIR - `IDX_INDIRECT_DATA)];
    assign port_b_dir            = st_ff.regs[5'(`IDX_PORT_B_DIR - `IDX_INDIRECT_DATA)];
    assign port_b_pullup         = st_ff.regs[5'(`IDX_PORT_B_PULLUP - `IDX_INDIRECT_DATA)];
    assign prescaler_edge_option = st_ff.regs[5'(`IDX_PRESCALER_OPTION - `IDX_INDIRECT_DATA)];

endmodule
`default_nettype wire

// ---- bench/bank_one_checker.sv ----
/*
 * Concurrent checks on the APB side, port latches and reset-driven outputs.
 * Assumes a bind into the bank top; sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module bank_one_checker (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [9:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        watchdog_reset_source,
    input wire logic        brownout_reset,
    input wire logic        external_reset_pin_n,
    input wire logic [7:0]  port_a_latch,
    input wire logic [7:0]  port_b_latch,
    input wire logic [7:0]  port_a_dir,
    input wire logic [7:0]  port_b_dir,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // ============================================================
    // bus handshake
    property p_ready_after_setup;
        psel && !penable |=> pready;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("no pready after setup");
    property p_ready_single;
        pready |=> !pready;
    endproperty
    a_ready_single: assert property (p_ready_single) else $error("pready held");

    // ============================================================
    // holes in the map
    property p_misaligned;
        pready && paddr[1:0] != 2'b00 |-> pslverr && prdata == 32'h0;
    endproperty
    a_misaligned: assert property (p_misaligned) else $error("misaligned not refused");
    property p_unmapped;
        pready && (paddr[9:2] < 8'h80 || paddr[9:2] > 8'hA7) |-> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
    property p_upper_zero;
        pready |-> prdata[31:8] == 24'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");

    // ============================================================
    // resets other than power-on
    property p_latch_watchdog;
        watchdog_reset_source && !(psel && penable && pwrite) |=>
            $stable(port_a_latch) && $stable(port_b_latch);
    endproperty
    a_latch_watchdog: assert property (p_latch_watchdog) else $error("latch lost on watchdog");
    property p_latch_pin;
        !external_reset_pin_n && !psel |=> $stable(port_a_latch) && $stable(port_b_latch);
    endproperty
    a_latch_pin: assert property (p_latch_pin) else $error("latch lost on reset pin");
    property p_dir_watchdog;
        watchdog_reset_source |=> port_a_dir == 8'hFF && port_b_dir == 8'hFF;
    endproperty
    a_dir_watchdog: assert property (p_dir_watchdog) else $error("direction not reset");
    property p_dir_brownout;
        brownout_reset |=> port_a_dir == 8'hFF && port_b_dir == 8'hFF;
    endproperty
    a_dir_brownout: assert property (p_dir_brownout) else $error("direction not reset");

    c_watchdog: cover property (watchdog_reset_source);
    c_refused: cover property (pready && pslverr);
    c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// ---- bench/special_register_bank_one_tb.sv ----
/*
 * Self-checking bench for the second special register bank.
 * Assumes zero APB wait states; index = address / 4.
 */
`timescale 1ns/1ps
`default_nettype none
module special_register_bank_one_tb import bank_types_pkg::*;;
    logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, irq, rd_err;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata, rd_data;
    logic [3:0]  sync_serial_mode_select;
    logic [7:0]  port_a_pins, port_b_pins, port_a_latch, port_b_latch;
    logic [7:0]  port_a_dir, port_b_dir, port_b_pullup, prescaler_edge_option;
    logic        external_reset_pin_n, watchdog_reset_source, brownout_reset;
    int          failures, total_checks, cycles;
    logic [2:0]  osc_status = 3'h0;

    special_register_bank_one dut (.*);

    // ============================================================
    // shared tasks
    task automatic end_of_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [32:0] seen, input logic [32:0] expected);
        total_checks++;
        if (seen !== expected) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask
    // entered just after a rising edge; returns one edge after the edge that took pready
    task automatic apb(input logic wr, input logic [9:0] addr, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, {idx, 2'b00}, {24'h0, d});
    endtask
    task automatic expect_reg(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e);
        apb(1'b0, {idx, 2'b00}, 32'h0);
        check({rd_err, rd_data & {24'h0, m}}, {1'b0, 24'h0, e});
    endtask
    task automatic pulse_wait(input int n);
        repeat (n) @(posedge clk);
    endtask

    // ============================================================
    // scenarios
    task automatic reset_values();
        logic [7:0] idx [10] = '{8'h81, 8'h83, 8'h85, 8'h89, 8'h8D, 8'h8F, 8'h92, 8'h93,
                                 8'h98, 8'h9D};
        logic [7:0] val [10] = '{8'hFF, 8'h18, 8'hFF, 8'h0F, 8'h00, 8'h60, 8'hFF, 8'h00,
                                 8'h02, 8'h01};
        for (int i = 0; i < 10; i++) begin
            expect_reg(idx[i], 8'hFF, val[i]);
        end
    endtask
    task automatic analog_read();
        port_a_pins <= 8'hC3;
        pulse_wait(4);
        expect_reg(8'hA6, 8'hFF, 8'h00);
        wr(8'hA2, 8'h0F);
        expect_reg(8'hA6, 8'hFF, 8'hC0);
    endtask
    task automatic unimplemented();
        wr(8'h89, 8'hFF);
        expect_reg(8'h89, 8'hFF, 8'h0F);
        wr(8'h80, 8'h5A);
        expect_reg(8'h80, 8'hFF, 8'h00);
        wr(8'h9F, 8'hFF);
        expect_reg(8'h9F, 8'hFF, 8'hB0);
        apb(1'b0, 10'h241, 32'h0);
        check({rd_err, rd_data}, {1'b1, 32'h0});
        apb(1'b1, 10'h040, 32'hFF);
        check({rd_err, rd_data}, {1'b1, 32'h0});
    endtask
    task automatic alias_mask();
        wr(8'h93, 8'h5A);
        sync_serial_mode_select <= 4'h9;
        expect_reg(8'h93, 8'hFF, 8'hFF);
        wr(8'h93, 8'h3C);
        for (int m = 0; m < 16; m++) begin
            sync_serial_mode_select <= m[3:0];
            expect_reg(8'h93, 8'hFF, (m == 9) ? 8'h3C : 8'h5A);
        end
    endtask
    task automatic latch_keep();
        wr(8'hA0, 8'hA5);
        wr(8'h85, 8'h00);
        watchdog_reset_source <= 1'b1;
        pulse_wait(1);
        watchdog_reset_source <= 1'b0;
        pulse_wait(1);
        check(port_a_latch, 8'hA5);
        check(port_a_dir, 8'hFF);
        external_reset_pin_n <= 1'b0;
        pulse_wait(4);
        external_reset_pin_n <= 1'b1;
        pulse_wait(4);
        check(port_a_latch, 8'hA5);
        wr(8'h86, 8'h00);
        brownout_reset <= 1'b1;
        pulse_wait(1);
        brownout_reset <= 1'b0;
        pulse_wait(1);
        check(port_b_dir, 8'hFF);
    endtask
    task automatic change_flag();
        wr(8'hA3, 8'h00);
        wr(8'h96, 8'h01);
        expect_reg(8'hA7, 8'h01, 8'h00);
        port_b_pins <= 8'h01;
        pulse_wait(6);
        expect_reg(8'h8B, 8'h01, 8'h01);
        expect_reg(8'hA4, 8'h01, 8'h01);
        check(irq, 1'b0);
        wr(8'hA5, 8'h01);
        pulse_wait(2);
        check(irq, 1'b1);
        wr(8'hA4, 8'h01);
        pulse_wait(2);
        check(irq, 1'b0);
        // pins stay high: mismatch outlives the reset
        watchdog_reset_source <= 1'b1;
        pulse_wait(1);
        watchdog_reset_source <= 1'b0;
        pulse_wait(6);
        expect_reg(8'h8B, 8'h01, 8'h00);
        wr(8'hA3, 8'h00);
        wr(8'h96, 8'h01);
        pulse_wait(6);
        expect_reg(8'h8B, 8'h01, 8'h01);
    endtask

    // ============================================================
    // clock, watchdog on the run, main sequence
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end
    initial begin
        reset_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        sync_serial_mode_select = 4'h0;
        {port_a_pins, port_b_pins} = '0;
        {watchdog_reset_source, brownout_reset} = '0;
        external_reset_pin_n = 1'b1;
        pulse_wait(2);
        reset_n <= 1'b1;
        pulse_wait(1);
        reset_values();
        analog_read();
        unimplemented();
        alias_mask();
        latch_keep();
        change_flag();
        end_of_test();
    end
endmodule

bind special_register_bank_one bank_one_checker u_checker (.*);
`default_nettype wire
